// ==== logic/lbhb_pkg.sv ====
// Constants, register map and types for the local bus host bridge port.
// Assumes a single 125 MHz clock domain and an Avalon-MM register slave with byte addresses.
package lbhb_pkg;
   localparam int DW = 16;
   localparam int AW = 20;
   localparam int CAW = 16;
   localparam int CFG_WORDS = 4;
   // Register byte offsets.
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_ADDR = 6'h04;
   localparam logic [5:0] REG_WDATA = 6'h08;
   localparam logic [5:0] REG_CMD = 6'h0c;
   localparam logic [5:0] REG_STAT = 6'h10;
   localparam logic [5:0] REG_RDATA = 6'h14;
   localparam logic [1:0] CFG_WIN = 2'h2;
   // Field positions and reset values.
   localparam int CTRL_WIDTH_BIT = 0;
   localparam int CTRL_ARB_BIT = 1;
   localparam int CTRL_CLKEN_BIT = 2;
   localparam logic [2:0] CTRL_RST = 3'h5;
   localparam int CMD_READ_BIT = 4;
   localparam logic [2:0] STROBE_CYC = 3'h4;
   localparam logic ROLE_BRIDGE = 1'h0;
   localparam logic STYLE_SELECT = 1'h1;
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} lbhb_state_t;
endpackage

// ==== logic/lbhb_sync.sv ====
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk_in; only the second stage may be read.
`timescale 1ns/10ps
module lbhb_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RV = '0
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Data
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta_r <= RV;
         q_out <= RV;
      end else begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule // lbhb_sync

// ==== logic/lbhb_lane.sv ====
// Byte lane choice for a bridge access from host byte enables and bus width.
// Assumes purely combinational use by the bridge sequencer.
`timescale 1ns/10ps
module lbhb_lane (
   // Selection inputs
   input wire logic [3:0] be_in,
   input wire logic word_sel_in,
   input wire logic wide_in,
   // Lane outputs
   output logic use_low_out,
   output logic use_high_out
);
   wire [1:0] sel = word_sel_in ? be_in[3:2] : be_in[1:0];

   // A narrow bus only ever carries the low lanes.
   assign use_high_out = wide_in & sel[1];
   assign use_low_out = ~wide_in | sel[0] | ~sel[1];
endmodule // lbhb_lane

// ==== logic/lbhb_port.sv ====
// Local bus port: bridge master or configuration slave, picked by pin straps.
// Assumes straps are static during operation and that pins are resolved outside from the enables.
// What this block does
// R1 - Role strap low makes the port bus master; high makes it a configured slave.
// R2 - Style strap picks separate strobes (0) or select plus data strobe (1).
// R3 - Bridge drives data on writes and samples data on reads at clock edges.
// R4 - Bridge uses both bytes, low byte or high byte per byte enables and width.
// R5 - High-byte enable is asserted for the whole access using upper data lanes.
// R6 - Bridge releases all data lines when no access is in progress.
// R7 - Configuration role accepts only whole 16-bit word accesses.
// R8 - Configuration role drives register data during a host read, then releases.
// R9 - Bridge drives address lines during an access and releases them when idle.
// R10 - Configuration role decodes only the low sixteen address lines.
// R11 - Bridge write line marks writes, or encodes read versus write in select style.
// R12 - With arbitration on, control lines float between accesses; otherwise always driven in bridge role.
// R13 - Configuration role samples the write line as write mark or direction select.
// R14 - Bridge read line marks reads, or acts as data strobe in select style.
// R15 - Configuration role samples read line as read mark, or as data strobe for reads and writes in select style.
// R16 - External host must assert chip select; ignored in bridge role.
// R17 - Local clock output is a copy of the system clock, floated in configuration role.
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
module lbhb_port (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Avalon-MM register slave
   input wire logic [5:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Straps
   input wire logic bus_role_select_in,
   input wire logic bus_style_select_in,
   // Local data and address
   input wire logic [15:0] local_data_lines_in,
   output logic [15:0] local_data_lines_out,
   output logic local_data_lines_oe_out,
   input wire logic [19:0] local_address_lines_in,
   output logic [19:0] local_address_lines_out,
   output logic local_address_lines_oe_out,
   // Local control lines
   input wire logic write_line_n_in,
   output logic write_line_n_out,
   output logic write_line_n_oe_out,
   input wire logic read_line_n_in,
   output logic read_line_n_out,
   output logic read_line_n_oe_out,
   output logic high_byte_enable_n_out,
   output logic high_byte_enable_n_oe_out,
   input wire logic chip_select_n_in,
   // Local clock
   output logic local_bus_clock_out,
   output logic local_bus_clock_oe_out
);
   logic [31:0] sy_bus;
   logic [4:0] sy_ctl;
   logic [2:0] ctrl_r;
   logic [19:0] baddr_r;
   logic [15:0] wdata_r;
   logic [15:0] rdata_r;
   logic [3:0] be_r;
   logic dir_rd_r;
   lbhb_pkg::lbhb_state_t state_r;
   lbhb_pkg::lbhb_state_t state_nxt;
   logic [2:0] cnt_r;
   logic [2:0] cnt_nxt;
   logic rack_r;
   logic [31:0] rdq_r;
   logic [15:0] cfg_mem [lbhb_pkg::CFG_WORDS];
   logic hwr_p_r;
   logic [15:0] hwd_r;
   logic [15:0] hwa_r;
   logic [15:0] cfg_rd_r;
   logic hrd_act_r;
   logic use_low;
   logic use_high;

   // The top four address inputs are never synchronised: they play no part in decoding.
   lbhb_sync #(.W(32), .RV(32'h0)) u_sync_bus (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .d_in({local_address_lines_in[15:0], local_data_lines_in}),
      .q_out(sy_bus)
   );

   lbhb_sync #(.W(5), .RV(5'h07)) u_sync_ctl (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .d_in({bus_role_select_in, bus_style_select_in, chip_select_n_in, write_line_n_in, read_line_n_in}),
      .q_out(sy_ctl)
   );

   wire bridge = sy_ctl[4] == lbhb_pkg::ROLE_BRIDGE; // R1
   wire sel_style = sy_ctl[3] == lbhb_pkg::STYLE_SELECT; // R2
   wire cs_n = sy_ctl[2];
   wire hwr_n = sy_ctl[1];
   wire hrd_n = sy_ctl[0];
   wire [15:0] hd = sy_bus[15:0];
   wire [15:0] ha = sy_bus[31:16];
   wire arb_en = ctrl_r[lbhb_pkg::CTRL_ARB_BIT];
   wire busy = state_r != lbhb_pkg::ST_IDLE;
   wire strobe = state_r == lbhb_pkg::ST_STROBE;

   lbhb_lane u_lane (
      .be_in(be_r),
      .word_sel_in(baddr_r[1]),
      .wide_in(ctrl_r[lbhb_pkg::CTRL_WIDTH_BIT]),
      .use_low_out(use_low),
      .use_high_out(use_high)
   ); // R4

   // Register slave decode. Reads take one wait cycle so that read data come from a flop.
   wire cmd_hit = avs_address_in == lbhb_pkg::REG_CMD;
   wire cfg_hit = avs_address_in[5:4] == lbhb_pkg::CFG_WIN;
   wire [1:0] cfg_idx = avs_address_in[3:2];
   assign avs_waitrequest_out = (avs_read_in & ~rack_r) | (avs_write_in & cmd_hit & busy);
   wire wr_go = avs_write_in & ~avs_waitrequest_out;
   wire start = wr_go & cmd_hit & bridge;
   wire [31:0] rd_mux =
      (avs_address_in == lbhb_pkg::REG_CTRL) ? {29'h0, ctrl_r} :
      (avs_address_in == lbhb_pkg::REG_ADDR) ? {12'h0, baddr_r} :
      (avs_address_in == lbhb_pkg::REG_WDATA) ? {16'h0, wdata_r} :
      cmd_hit ? {27'h0, dir_rd_r, be_r} :
      (avs_address_in == lbhb_pkg::REG_STAT) ? {29'h0, sel_style, ~bridge, busy} :
      (avs_address_in == lbhb_pkg::REG_RDATA) ? {16'h0, rdata_r} :
      cfg_hit ? {16'h0, cfg_mem[cfg_idx]} : 32'h0;
   assign avs_readdata_out = rdq_r;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rack_r <= 1'h0;
         rdq_r <= 32'h0;
      end else begin
         rack_r <= avs_read_in & ~rack_r;
         rdq_r <= rd_mux;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctrl_r <= lbhb_pkg::CTRL_RST;
         baddr_r <= 20'h0;
         wdata_r <= 16'h0;
         be_r <= 4'h0;
         dir_rd_r <= 1'h0;
      end else if (wr_go) begin
         if (avs_address_in == lbhb_pkg::REG_CTRL) begin
            ctrl_r <= avs_writedata_in[2:0];
         end
         if (avs_address_in == lbhb_pkg::REG_ADDR) begin
            baddr_r <= avs_writedata_in[19:0];
         end
         if (avs_address_in == lbhb_pkg::REG_WDATA) begin
            wdata_r <= avs_writedata_in[15:0];
         end
         if (start) begin
            be_r <= avs_writedata_in[3:0];
            dir_rd_r <= avs_writedata_in[lbhb_pkg::CMD_READ_BIT];
         end
      end
   end

   // Bridge sequencer: one setup cycle, a fixed strobe, one hold cycle with address still out.
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         lbhb_pkg::ST_IDLE: begin
            if (start) begin
               state_nxt = lbhb_pkg::ST_SETUP;
            end
         end
         lbhb_pkg::ST_SETUP: begin
            state_nxt = lbhb_pkg::ST_STROBE;
            cnt_nxt = lbhb_pkg::STROBE_CYC - 3'h1;
         end
         lbhb_pkg::ST_STROBE: begin
            if (cnt_r == 3'h0) begin
               state_nxt = lbhb_pkg::ST_HOLD;
            end else begin
               cnt_nxt = cnt_r - 3'h1;
            end
         end
         default: begin
            state_nxt = lbhb_pkg::ST_IDLE;
         end
      endcase
   end

   // Data seen through the synchroniser lags the pins by two cycles, still inside the strobe.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_r <= lbhb_pkg::ST_IDLE;
         cnt_r <= 3'h0;
         rdata_r <= 16'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         if (strobe && cnt_r == 3'h0 && dir_rd_r) begin
            rdata_r <= hd; // R3
         end
      end
   end

   // Bridge pin drive.
   wire ctl_oe = bridge & (busy | ~arb_en); // R12
   assign local_address_lines_out = baddr_r;
   assign local_address_lines_oe_out = bridge & busy; // R9
   assign write_line_n_out = sel_style ? ~(busy & ~dir_rd_r) : ~(strobe & ~dir_rd_r); // R11
   assign read_line_n_out = sel_style ? ~strobe : ~(strobe & dir_rd_r); // R14
   assign write_line_n_oe_out = ctl_oe;
   assign read_line_n_oe_out = ctl_oe;
   assign high_byte_enable_n_out = ~(busy & use_high); // R5
   assign high_byte_enable_n_oe_out = ctl_oe;
   assign local_data_lines_out = bridge ? wdata_r : cfg_rd_r;
   assign local_data_lines_oe_out = bridge ? (busy & ~dir_rd_r) : hrd_act_r; // R3 R6 R8
   // The forwarded clock is a buffered copy; gating is left to the pad enable.
   assign local_bus_clock_out = clk_in;
   assign local_bus_clock_oe_out = bridge & ctrl_r[lbhb_pkg::CTRL_CLKEN_BIT]; // R17

   // Configuration role host decode.
   wire h_wr = ~bridge & ~cs_n & (sel_style ? (~hrd_n & ~hwr_n) : ~hwr_n); // R13 R15 R16
   wire h_rd = ~bridge & ~cs_n & (sel_style ? (~hrd_n & hwr_n) : ~hrd_n); // R15 R16
   wire rd_mapped = ha[15:2] == 14'h0; // R10
   wire wr_mapped = hwa_r[15:2] == 14'h0; // R10
   // A host write lands when its strobe ends, so address and data have settled.
   wire commit = hwr_p_r & ~h_wr & wr_mapped; // R7 R15

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hwr_p_r <= 1'h0;
         hwd_r <= 16'h0;
         hwa_r <= 16'h0;
         cfg_rd_r <= 16'h0;
         hrd_act_r <= 1'h0;
      end else begin
         hwr_p_r <= h_wr;
         if (h_wr) begin
            hwd_r <= hd;
            hwa_r <= ha;
         end
         cfg_rd_r <= rd_mapped ? cfg_mem[ha[1:0]] : 16'h0;
         hrd_act_r <= h_rd; // R8
      end
   end

   // Host writes win over a register-bus write in the same cycle.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < lbhb_pkg::CFG_WORDS; i++) begin
            cfg_mem[i] <= 16'h0;
         end
      end else if (commit) begin
         cfg_mem[hwa_r[1:0]] <= hwd_r; // R7
      end else if (wr_go && cfg_hit) begin
         if (avs_byteenable_in[0]) begin
            cfg_mem[cfg_idx][7:0] <= avs_writedata_in[7:0];
         end
         if (avs_byteenable_in[1]) begin
            cfg_mem[cfg_idx][15:8] <= avs_writedata_in[15:8];
         end
      end
   end

   property p_data_rel;
      @(posedge clk_in) disable iff (!nrst_in) (bridge && !busy) |-> !local_data_lines_oe_out;
   endproperty
   a_data_rel: assert property (p_data_rel) else $error("data lines driven while bridge idle"); // R6

   property p_addr_span;
      @(posedge clk_in) disable iff (!nrst_in)
         start |=> local_address_lines_oe_out [*6] ##1 !local_address_lines_oe_out;
   endproperty
   a_addr_span: assert property (p_addr_span) else $error("address drive span wrong"); // R9

   property p_wr_strobe;
      @(posedge clk_in) disable iff (!nrst_in)
         (start && !avs_writedata_in[4] && !sel_style) |=>
         write_line_n_out ##1 !write_line_n_out [*4] ##1 write_line_n_out;
   endproperty
   a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe timing wrong"); // R11

   property p_rd_strobe;
      @(posedge clk_in) disable iff (!nrst_in)
         (start && avs_writedata_in[4] && !sel_style) |=>
         read_line_n_out ##1 !read_line_n_out [*4] ##1 read_line_n_out && write_line_n_out;
   endproperty
   a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe timing wrong"); // R14

   property p_sel_write;
      @(posedge clk_in) disable iff (!nrst_in)
         (start && !avs_writedata_in[4] && sel_style) |=>
         (!write_line_n_out && read_line_n_out) ##1 (!read_line_n_out && !write_line_n_out) [*4];
   endproperty
   a_sel_write: assert property (p_sel_write) else $error("select style write wrong"); // R11

   property p_hbe;
      @(posedge clk_in) disable iff (!nrst_in)
         (busy && use_high) |-> (!high_byte_enable_n_out && high_byte_enable_n_oe_out);
   endproperty
   a_hbe: assert property (p_hbe) else $error("high byte enable not asserted"); // R5

   property p_arb;
      @(posedge clk_in) disable iff (!nrst_in)
         bridge |-> (write_line_n_oe_out == (busy || !arb_en));
   endproperty
   a_arb: assert property (p_arb) else $error("control drive does not follow arbitration"); // R12

   property p_cfg_rel;
      @(posedge clk_in) disable iff (!nrst_in) (!bridge && !h_rd) |=> !local_data_lines_oe_out;
   endproperty
   a_cfg_rel: assert property (p_cfg_rel) else $error("config read data not released"); // R8

   property p_clk;
      @(posedge clk_in) disable iff (!nrst_in) !bridge |-> !local_bus_clock_oe_out;
   endproperty
   a_clk: assert property (p_clk) else $error("local clock driven in config role"); // R17

   property p_commit;
      @(posedge clk_in) disable iff (!nrst_in) commit |=> cfg_mem[$past(hwa_r[1:0])] == $past(hwd_r);
   endproperty
   a_commit: assert property (p_commit) else $error("host word write lost"); // R13

   property p_lane;
      @(posedge clk_in) disable iff (!nrst_in) busy |-> (use_low || use_high);
   endproperty
   a_lane: assert property (p_lane) else $error("bridge access without a data lane"); // R4
endmodule // lbhb_port

// ==== bench/lbhb_periph.sv ====
// Bridge-side peripheral model: sixteen words answering both strobe styles.
// Assumes the bench resolves the data wire and feeds data_out only when the port does not drive.
`timescale 1ns/10ps
module lbhb_periph (
   // Clock and style strap
   input wire logic clk_in,
   input wire logic style_in,
   // Port pins as driven
   input wire logic [19:0] addr_in,
   input wire logic [15:0] data_in,
   input wire logic wr_n_in,
   input wire logic rd_n_in,
   input wire logic hbe_n_in,
   // Answer to the port
   output logic [15:0] data_out,
   output logic hbe_seen_out
);
   logic [15:0] mem [0:15];
   logic rd_prev_r = 1'b1;
   logic [15:0] last_r = 16'h0000;
   logic hbe_seen_r = 1'b0;
   // Released lines show a changing pattern, so a stale sample cannot pass.
   wire rd_act = style_in ? (!rd_n_in && wr_n_in) : !rd_n_in;
   wire strobe = !rd_n_in || (!style_in && !wr_n_in);
   assign data_out = rd_act ? mem[addr_in[3:0]] : ~last_r;
   assign hbe_seen_out = hbe_seen_r;
   always @(posedge clk_in) begin
      rd_prev_r <= rd_n_in;
      last_r <= data_out;
      if (!style_in && !wr_n_in) mem[addr_in[3:0]] <= data_in;
      if (style_in && rd_n_in && !rd_prev_r && !wr_n_in) mem[addr_in[3:0]] <= data_in;
      if (strobe) hbe_seen_r <= !hbe_n_in;
   end
endmodule // lbhb_periph

// ==== bench/lbhb_port_tb.sv ====
// Testbench for the local bus port: register bus tasks, bridge accesses and host pin accesses.
// Assumes the peripheral model stands on the bridge side and the bench plays the configuring host.
`timescale 1ns/10ps
module lbhb_port_tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [5:0] a_addr = 6'h00;
   logic a_rd = 1'b0;
   logic a_wr = 1'b0;
   logic [31:0] a_wd = 32'h0;
   logic [31:0] a_q;
   logic a_wait;
   logic role = 1'b0;
   logic style = 1'b0;
   logic [15:0] h_d = 16'h0;
   logic [19:0] h_a = 20'h0;
   logic h_wr_n = 1'b1;
   logic h_rd_n = 1'b1;
   logic h_cs_n = 1'b1;
   logic [15:0] d_out, p_d, d_in;
   logic [19:0] ad_out;
   logic d_oe, ad_oe, wr_o, wr_oe, rd_o, rd_oe, hbe_o, hbe_oe, local_bus_clock, local_bus_clock_oe, hbe_seen;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [31:0] q;
   assign d_in = d_oe ? d_out : (role ? h_d : p_d);
   lbhb_port u_dut (.clk_in(clk), .nrst_in(nrst), .avs_address_in(a_addr), .avs_read_in(a_rd),
      .avs_write_in(a_wr), .avs_writedata_in(a_wd), .avs_byteenable_in(4'hf), .avs_readdata_out(a_q),
      .avs_waitrequest_out(a_wait), .bus_role_select_in(role), .bus_style_select_in(style),
      .local_data_lines_in(d_in), .local_data_lines_out(d_out), .local_data_lines_oe_out(d_oe),
      .local_address_lines_in(h_a), .local_address_lines_out(ad_out), .local_address_lines_oe_out(ad_oe),
      .write_line_n_in(wr_oe ? wr_o : h_wr_n), .write_line_n_out(wr_o), .write_line_n_oe_out(wr_oe),
      .read_line_n_in(rd_oe ? rd_o : h_rd_n), .read_line_n_out(rd_o), .read_line_n_oe_out(rd_oe),
      .high_byte_enable_n_out(hbe_o), .high_byte_enable_n_oe_out(hbe_oe), .chip_select_n_in(h_cs_n),
      .local_bus_clock_out(local_bus_clock), .local_bus_clock_oe_out(local_bus_clock_oe));
   lbhb_periph u_periph (.clk_in(clk), .style_in(style), .addr_in(ad_out), .data_in(d_out),
      .wr_n_in(wr_o), .rd_n_in(rd_o), .hbe_n_in(hbe_o), .data_out(p_d), .hbe_seen_out(hbe_seen));
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic give_verdict;
      if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Holds the request until waitrequest is seen low at a rising edge; data are taken at that edge.
   task automatic avs(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
      a_addr <= a;
      a_wd <= d;
      a_wr <= w;
      a_rd <= !w;
      do @(posedge clk); while (a_wait !== 1'b0);
      r = a_q;
      a_wr <= 1'b0;
      a_rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_idle;
      logic [31:0] s;
      do avs(1'b0, lbhb_pkg::REG_STAT, 32'h0, s); while (s[0] !== 1'b0);
   endtask
   // Bridge write then read of one word; the second command stalls until the first ends.
   // The high-byte expectation follows the lane pairing of address bit 1, byte enables and width.
   task automatic bridge(input logic [19:0] a, input logic [15:0] d, input logic [3:0] be, input logic hb);
      avs(1'b1, lbhb_pkg::REG_ADDR, {12'h000, a}, q);
      avs(1'b1, lbhb_pkg::REG_WDATA, {16'h0000, d}, q);
      avs(1'b1, lbhb_pkg::REG_CMD, {28'h0000000, be}, q);
      avs(1'b1, lbhb_pkg::REG_CMD, 32'h00000013, q);
      // The read strobe has not begun yet, so the model still holds what the write strobe saw.
      chk("hbe during write", {31'h0, hb}, {31'h0, hbe_seen});
      wait_idle();
      avs(1'b0, lbhb_pkg::REG_RDATA, 32'h0, q);
   endtask
   task automatic host(input logic w, input logic [19:0] a, input logic [15:0] d);
      h_cs_n <= 1'b0;
      h_a <= a;
      h_d <= d;
      h_wr_n <= !w;
      h_rd_n <= style ? 1'b0 : w;
      repeat (5) @(posedge clk);
      if (!w) chk("host read data", {15'h0, 1'b1, d}, {15'h0, d_oe, d_out});
      h_cs_n <= 1'b1;
      h_wr_n <= 1'b1;
      h_rd_n <= 1'b1;
      h_d <= ~d;
      repeat (4) @(posedge clk);
      chk("host data oe after", 32'h0, {31'h0, d_oe});
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      avs(1'b0, lbhb_pkg::REG_CTRL, 32'h0, q);
      chk("ctrl reset", 32'h00000005, q);
      avs(1'b0, 6'h3c, 32'h0, q);
      chk("unmapped read", 32'h0, q);
      // Look in the middle of the high phase, where the forwarded clock has settled.
      #2;
      chk("clock out", {31'h0, clk}, {31'h0, local_bus_clock});
      chk("idle oe", 32'h0000001c, {27'h0, local_bus_clock_oe, wr_oe, rd_oe, d_oe, ad_oe});
      @(posedge clk);
      bridge(20'h00004, 16'ha55a, 4'h3, 1'b1);
      chk("wide word", 32'h0000a55a, q);
      avs(1'b1, lbhb_pkg::REG_CTRL, 32'h00000004, q);
      bridge(20'h00008, 16'h12c3, 4'h1, 1'b0);
      chk("narrow low byte", 32'h000000c3, {24'h0, q[7:0]});
      avs(1'b1, lbhb_pkg::REG_CTRL, 32'h00000007, q);
      bridge(20'h0000c, 16'h7e00, 4'h2, 1'b1);
      chk("high byte", 32'h0000007e, {24'h0, q[15:8]});
      chk("arb idle oe", 32'h0, {27'h0, wr_oe, rd_oe, hbe_oe, d_oe, ad_oe});
      style <= 1'b1;
      repeat (3) @(posedge clk);
      bridge(20'h00002, 16'h3cc3, 4'hc, 1'b1);
      chk("select style word", 32'h00003cc3, q);
      role <= 1'b1;
      style <= 1'b0;
      repeat (3) @(posedge clk);
      chk("config clock oe", 32'h0, {31'h0, local_bus_clock_oe});
      host(1'b1, 20'h00002, 16'hbeef);
      avs(1'b0, 6'h28, 32'h0, q);
      chk("host written word", 32'h0000beef, {16'h0, q[15:0]});
      avs(1'b1, 6'h24, 32'h00005a0f, q);
      host(1'b0, 20'h00001, 16'h5a0f);
      // Select style on the host side: the data strobe with the direction select.
      style <= 1'b1;
      repeat (3) @(posedge clk);
      host(1'b1, 20'h00003, 16'h1234);
      host(1'b0, 20'h00003, 16'h1234);
      avs(1'b0, 6'h2c, 32'h0, q);
      chk("select host word", 32'h00001234, {16'h0, q[15:0]});
      give_verdict();
   end
endmodule // lbhb_port_tb
